// >>> common/pcgf_pkg.sv
// pcgf_pkg: constants shared by the codec strobe and gci frame block
// assumes: 32-bit avalon-mm register bus, byte addresses, one word per register
package pcgf_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADR_PCM_MODE = 5'h00;
  localparam logic [4:0] ADR_MUX_DATA = 5'h04;
  localparam logic [4:0] ADR_GCI_CFG = 5'h08;
  localparam logic [4:0] ADR_GCI_CMD = 5'h0c;
  localparam logic [4:0] ADR_MON_TX = 5'h10;
  localparam logic [4:0] ADR_GCI_STAT = 5'h14;
  // multiplex index values
  localparam logic [3:0] IDX_SLOT_A = 4'h0;
  localparam logic [3:0] IDX_SLOT_B = 4'h1;
  localparam logic [3:0] IDX_PAT0_LO = 4'hc;
  localparam logic [3:0] IDX_PAT0_HI = 4'hd;
  localparam logic [3:0] IDX_PAT1_LO = 4'he;
  localparam logic [3:0] IDX_PAT1_HI = 4'hf;
  // field positions
  localparam int MODE_FSZ_LSB = 4;
  localparam int SLOT_CHOICE_BIT = 7;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_CI6_BIT = 1;
  localparam int CFG_SWAP_BIT = 2;
  localparam int CFG_GRP_LSB = 8;
  // frame size codes and half-bit frame lengths minus one
  localparam logic [1:0] FSZ_32 = 2'h0;
  localparam logic [1:0] FSZ_64 = 2'h1;
  localparam logic [10:0] HB_LAST_32 = 11'h1ff;
  localparam logic [10:0] HB_LAST_64 = 11'h3ff;
  localparam logic [10:0] HB_LAST_128 = 11'h7ff;
  // shape pattern length and its done marker
  localparam logic [4:0] PAT_DONE = 5'h10;
  // gci byte positions within the group, idle values
  localparam logic [1:0] GCI_MON_SLOT = 2'h2;
  localparam logic [1:0] GCI_CI_SLOT = 2'h3;
  localparam logic [7:0] MON_IDLE = 8'hff;
  localparam logic HS_IDLE = 1'b1;
endpackage : pcgf_pkg

// >>> logic/pcgf_sync.sv
// pcgf_sync: two-flop synchroniser for a group of pin inputs
// assumes: bits are independent levels; no bus coherence is needed
`timescale 1ns/1ps
`default_nettype none
module pcgf_sync #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pcgf_sync_t;
  pcgf_sync_t st_ff, nxt_st;

  // the first stage feeds only the second stage
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pin_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_sync = st_ff.stable;
endmodule : pcgf_sync
`default_nettype wire

// >>> logic/pcgf_strobe.sv
// pcgf_strobe: one codec enable waveform from a 16-step shape pattern
// assumes: step is a one-cycle enable per double-rate clock period
`timescale 1ns/1ps
`default_nettype none
module pcgf_strobe (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic step,
  input wire logic start,
  input wire logic [15:0] pattern,
  output logic strobe
);
  typedef struct packed {
    logic [4:0] pos;
    logic level;
  } pcgf_stb_t;
  pcgf_stb_t st_ff, nxt_st;

  // walk the shape once per slot
  always_comb begin
    nxt_st = st_ff;
    if (step) begin
      if (start) begin
        // low byte lsb goes out first
        nxt_st.level = pattern[0];
        nxt_st.pos = 5'h01;
      end else if (st_ff.pos != pcgf_pkg::PAT_DONE) begin
        nxt_st.level = pattern[st_ff.pos[3:0]];
        nxt_st.pos = st_ff.pos + 5'h01;
      end else begin
        // final bit is the idle level
        nxt_st.level = pattern[15];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '{pos: pcgf_pkg::PAT_DONE, level: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign strobe = st_ff.level;

  a_strobe_first: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    step && start |=> strobe == $past(pattern[0]))
    else $error("strobe did not open with pattern bit zero");
  a_strobe_idle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    step && !start && st_ff.pos == pcgf_pkg::PAT_DONE |=> strobe == $past(pattern[15]))
    else $error("strobe idle level differs from final pattern bit");
endmodule : pcgf_strobe
`default_nettype wire

// >>> logic/pcgf_top.sv
// pcgf_top: codec enable strobes and gci frame overlay on the pcm bus
// assumes: pcm pins come from another clock domain; avalon-mm master on core_clk
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module pcgf_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic double_rate_bit_clock,
  input wire logic frame_pulse,
  input wire logic serial_line_out_di,
  output logic serial_line_out_do,
  output logic serial_line_out_oe,
  input wire logic serial_line_in_di,
  output logic serial_line_in_do,
  output logic serial_line_in_oe,
  output logic codec_strobe_a,
  output logic codec_strobe_b
);
  typedef struct packed {
    logic [10:0] hb;
    logic dclk_q;
    logic fp_q;
    logic [3:0] idx;
    logic [1:0] fsz;
    logic [7:0] slot_a;
    logic [7:0] slot_b;
    logic [15:0] pat0;
    logic [15:0] pat1;
    logic gen;
    logic ci6;
    logic swap;
    logic [4:0] grp;
    logic [5:0] cmd;
    logic [5:0] cmd_sh;
    logic [7:0] mon_tx;
    logic mon_v;
    logic [7:0] mon_send;
    logic mx_out;
    logic mr_out;
    logic [7:0] rx_sh;
    logic [7:0] mon_cand;
    logic [7:0] mon_rx;
    logic mon_rxr;
    logic [5:0] ind;
    logic mr_in;
    logic mx_in;
    logic dout;
    logic oe_out;
    logic oe_in;
    logic [31:0] rdata;
    logic wait_r;
  } pcgf_st_t;
  pcgf_st_t st_ff, nxt_st;

  logic [3:0] pins_s;
  logic step, start_a, start_b;
  logic [10:0] hb_nxt;
  logic [6:0] slot_nxt, tgt_a, tgt_b, slot_mask;
  logic [6:0] gci_base;
  logic [2:0] bit_nxt;
  logic rx_bit;
  logic [7:0] ci_byte;
  logic [31:0] mux_rd;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  pcgf_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in({double_rate_bit_clock, frame_pulse, serial_line_out_di, serial_line_in_di}),
    .pin_sync(pins_s)
  );

  // ----------------------------------------------------------------
  // slot timing
  // ----------------------------------------------------------------
  // falling edge of the double-rate clock is one half-bit step
  assign step = st_ff.dclk_q && !pins_s[3];
  always_comb begin
    slot_mask = 7'h7f;
    if (st_ff.fsz == pcgf_pkg::FSZ_32) begin
      slot_mask = 7'h1f;
    end else if (st_ff.fsz == pcgf_pkg::FSZ_64) begin
      slot_mask = 7'h3f;
    end
    // a fresh frame pulse restarts at slot zero
    if (pins_s[2] && !st_ff.fp_q) begin
      hb_nxt = '0;
    end else if (st_ff.hb == {slot_mask, 4'hf}) begin
      hb_nxt = '0;
    end else begin
      hb_nxt = st_ff.hb + 11'h001;
    end
  end
  assign slot_nxt = hb_nxt[10:4];
  assign bit_nxt = hb_nxt[3:1];

  // slot field names the slot before the served one
  assign tgt_a = (st_ff.slot_a[6:0] + 7'h01) & slot_mask;
  assign tgt_b = (st_ff.slot_b[6:0] + 7'h01) & slot_mask;
  // each enable has its own slot
  assign start_a = step && hb_nxt[3:0] == 4'h0 && slot_nxt == tgt_a;
  assign start_b = step && hb_nxt[3:0] == 4'h0 && slot_nxt == tgt_b;

  // ----------------------------------------------------------------
  // codec strobes
  // ----------------------------------------------------------------
  // choice bit picks pattern pair zero or one
  pcgf_strobe u_stb_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .step(step),
    .start(start_a),
    .pattern(st_ff.slot_a[pcgf_pkg::SLOT_CHOICE_BIT] ? st_ff.pat1 : st_ff.pat0),
    .strobe(codec_strobe_a)
  );
  pcgf_strobe u_stb_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .step(step),
    .start(start_b),
    .pattern(st_ff.slot_b[pcgf_pkg::SLOT_CHOICE_BIT] ? st_ff.pat1 : st_ff.pat0),
    .strobe(codec_strobe_b)
  );

  // ----------------------------------------------------------------
  // gci overlay helpers
  // ----------------------------------------------------------------
  // group base is four times the slot group
  assign gci_base = {st_ff.grp, 2'b00};
  // swap exchanges which pin is the incoming line
  assign rx_bit = st_ff.swap ? pins_s[1] : pins_s[0];
  // fourth byte: d bits (when 4-bit c/i), c/i, mr, mx
  assign ci_byte = st_ff.ci6 ? {st_ff.cmd_sh, st_ff.mr_out, st_ff.mx_out}
                             : {2'b11, st_ff.cmd_sh[3:0], st_ff.mr_out, st_ff.mx_out};

  always_comb begin
    mux_rd = '0;
    case (st_ff.idx)
      pcgf_pkg::IDX_SLOT_A: mux_rd[7:0] = st_ff.slot_a;
      pcgf_pkg::IDX_SLOT_B: mux_rd[7:0] = st_ff.slot_b;
      pcgf_pkg::IDX_PAT0_LO: mux_rd[7:0] = st_ff.pat0[7:0];
      pcgf_pkg::IDX_PAT0_HI: mux_rd[7:0] = st_ff.pat0[15:8];
      pcgf_pkg::IDX_PAT1_LO: mux_rd[7:0] = st_ff.pat1[7:0];
      pcgf_pkg::IDX_PAT1_HI: mux_rd[7:0] = st_ff.pat1[15:8];
      default: mux_rd = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state: link side and register side
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.dclk_q = pins_s[3];
    if (step) begin
      nxt_st.fp_q = pins_s[2];
      nxt_st.hb = hb_nxt;
      // mid-bit: sample the incoming line
      if (hb_nxt[0]) begin
        nxt_st.rx_sh = {st_ff.rx_sh[6:0], rx_bit};
      end
      // only monitor and c/i slots are touched
      nxt_st.oe_out = 1'b0;
      nxt_st.oe_in = 1'b0;
      if (st_ff.gen && slot_nxt == gci_base + {5'h00, pcgf_pkg::GCI_MON_SLOT}) begin
        if (hb_nxt[3:0] == 4'h0) begin
          // idle monitor byte and idle mx when nothing queued
          nxt_st.mon_send = st_ff.mon_v ? st_ff.mon_tx : pcgf_pkg::MON_IDLE;
          nxt_st.mx_out = st_ff.mon_v ? ~pcgf_pkg::HS_IDLE : pcgf_pkg::HS_IDLE;
          nxt_st.mon_v = 1'b0;
          nxt_st.dout = st_ff.mon_v ? st_ff.mon_tx[7] : pcgf_pkg::MON_IDLE[7];
        end else begin
          nxt_st.dout = st_ff.mon_send[3'd7 - bit_nxt];
        end
        nxt_st.oe_out = !st_ff.swap;
        nxt_st.oe_in = st_ff.swap;
      end else if (st_ff.gen && slot_nxt == gci_base + {5'h00, pcgf_pkg::GCI_CI_SLOT}) begin
        // latch the command once, at the start of the c/i slot
        if (hb_nxt[3:0] == 4'h0) begin
          nxt_st.cmd_sh = st_ff.cmd;
          nxt_st.dout = st_ff.ci6 ? st_ff.cmd[5] : 1'b1;
        end else begin
          nxt_st.dout = ci_byte[3'd7 - bit_nxt];
        end
        // drive own mr/mx; d bits stay with the slot assigner
        nxt_st.oe_out = !st_ff.swap && (st_ff.ci6 || bit_nxt >= 3'd2);
        nxt_st.oe_in = st_ff.swap && (st_ff.ci6 || bit_nxt >= 3'd2);
      end
      // end of monitor slot: keep the byte as a candidate
      if (hb_nxt == {gci_base + {5'h00, pcgf_pkg::GCI_MON_SLOT}, 4'hf}) begin
        nxt_st.mon_cand = {st_ff.rx_sh[6:0], rx_bit};
      end
      // end of c/i slot: partner indication, mr and mx
      if (hb_nxt == {gci_base + {5'h00, pcgf_pkg::GCI_CI_SLOT}, 4'hf}) begin
        nxt_st.ind = st_ff.ci6 ? st_ff.rx_sh[6:1] : {2'b00, st_ff.rx_sh[4:1]};
        nxt_st.mr_in = st_ff.rx_sh[0];
        nxt_st.mx_in = rx_bit;
        nxt_st.mr_out = pcgf_pkg::HS_IDLE;
        if (st_ff.gen && rx_bit != pcgf_pkg::HS_IDLE) begin
          nxt_st.mon_rx = st_ff.mon_cand;
          nxt_st.mr_out = ~pcgf_pkg::HS_IDLE;
        end
      end
    end

    // avalon slave: one wait cycle, answer on the next edge
    nxt_st.wait_r = 1'b1;
    if ((avs_read || avs_write) && st_ff.wait_r) begin
      nxt_st.wait_r = 1'b0;
      nxt_st.rdata = '0;
      case (avs_address)
        pcgf_pkg::ADR_PCM_MODE: nxt_st.rdata[5:0] = {st_ff.fsz, st_ff.idx};
        pcgf_pkg::ADR_MUX_DATA: nxt_st.rdata = mux_rd;
        pcgf_pkg::ADR_GCI_CFG: nxt_st.rdata[12:0] = {st_ff.grp, 5'h00, st_ff.swap,
                                                       st_ff.ci6, st_ff.gen};
        pcgf_pkg::ADR_GCI_CMD: nxt_st.rdata[5:0] = st_ff.cmd;
        pcgf_pkg::ADR_MON_TX: nxt_st.rdata[7:0] = st_ff.mon_tx;
        pcgf_pkg::ADR_GCI_STAT: nxt_st.rdata[17:0] = {st_ff.mon_rxr, st_ff.mon_v,
                                   st_ff.mr_in, st_ff.mx_in, st_ff.ind, st_ff.mon_rx};
        default: nxt_st.rdata = '0;
      endcase
    end
    // the write lands on the edge where waitrequest is seen low
    if (!st_ff.wait_r && avs_read && avs_address == pcgf_pkg::ADR_GCI_STAT) begin
      nxt_st.mon_rxr = 1'b0;
    end
    if (!st_ff.wait_r && avs_write) begin
      case (avs_address)
        pcgf_pkg::ADR_PCM_MODE: begin
          nxt_st.idx = avs_writedata[3:0];
          nxt_st.fsz = avs_writedata[pcgf_pkg::MODE_FSZ_LSB +: 2];
        end
        pcgf_pkg::ADR_MUX_DATA: begin
          case (st_ff.idx)
            pcgf_pkg::IDX_SLOT_A: nxt_st.slot_a = avs_writedata[7:0];
            pcgf_pkg::IDX_SLOT_B: nxt_st.slot_b = avs_writedata[7:0];
            pcgf_pkg::IDX_PAT0_LO: nxt_st.pat0[7:0] = avs_writedata[7:0];
            pcgf_pkg::IDX_PAT0_HI: nxt_st.pat0[15:8] = avs_writedata[7:0];
            pcgf_pkg::IDX_PAT1_LO: nxt_st.pat1[7:0] = avs_writedata[7:0];
            pcgf_pkg::IDX_PAT1_HI: nxt_st.pat1[15:8] = avs_writedata[7:0];
            default: nxt_st.pat1 = st_ff.pat1;
          endcase
        end
        pcgf_pkg::ADR_GCI_CFG: begin
          // enable only by an explicit write of one
          nxt_st.gen = avs_writedata[pcgf_pkg::CFG_EN_BIT];
          nxt_st.ci6 = avs_writedata[pcgf_pkg::CFG_CI6_BIT];
          nxt_st.swap = avs_writedata[pcgf_pkg::CFG_SWAP_BIT];
          nxt_st.grp = avs_writedata[pcgf_pkg::CFG_GRP_LSB +: 5];
        end
        pcgf_pkg::ADR_GCI_CMD: nxt_st.cmd = avs_writedata[5:0];
        pcgf_pkg::ADR_MON_TX: begin
          nxt_st.mon_tx = avs_writedata[7:0];
          nxt_st.mon_v = 1'b1;
        end
        default: nxt_st.cmd = st_ff.cmd;
      endcase
    end
    // a received byte wins over a clear by status read
    if (step && st_ff.gen && rx_bit != pcgf_pkg::HS_IDLE
        && hb_nxt == {gci_base + {5'h00, pcgf_pkg::GCI_CI_SLOT}, 4'hf}) begin
      nxt_st.mon_rxr = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.wait_r <= 1'b1;
      st_ff.mx_out <= pcgf_pkg::HS_IDLE;
      st_ff.mr_out <= pcgf_pkg::HS_IDLE;
      st_ff.mon_send <= pcgf_pkg::MON_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_r;
  assign serial_line_out_do = st_ff.dout;
  assign serial_line_in_do = st_ff.dout;
  assign serial_line_out_oe = st_ff.oe_out;
  assign serial_line_in_oe = st_ff.oe_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_bus_answer: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_req_taken |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
  a_frame_zero: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    step && pins_s[2] && !st_ff.fp_q |=> st_ff.hb == 11'h000)
    else $error("slot counter not zero after frame pulse");
  a_gci_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !st_ff.gen && step |=> !serial_line_out_oe && !serial_line_in_oe)
    else $error("gci line driven while disabled");
  a_one_driver: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !(serial_line_out_oe && serial_line_in_oe))
    else $error("both data lines driven");
  a_slot_ahead: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    step && hb_nxt == 11'h000 && st_ff.slot_a[6:0] == slot_mask |-> start_a)
    else $error("all-ones slot field did not serve slot zero");
  a_mon_idle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    step && st_ff.gen && !st_ff.mon_v && hb_nxt[3:0] == 4'h0
    && slot_nxt == gci_base + 7'h02 |=> st_ff.dout && st_ff.mon_send == 8'hff)
    else $error("idle monitor byte is not all ones");
  a_cmd_latch: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    step && st_ff.gen && hb_nxt[3:0] == 4'h0 && slot_nxt == gci_base + 7'h03
    |=> st_ff.cmd_sh == $past(st_ff.cmd))
    else $error("command not taken at c/i slot start");
  a_mux_read: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    avs_read && avs_waitrequest && avs_address == 5'h04 && st_ff.idx == 4'hc
    |=> avs_readdata == {24'h000000, $past(st_ff.pat0[7:0])})
    else $error("index 0xc did not read pattern zero low");
endmodule : pcgf_top
`default_nettype wire

// >>> verif/pcgf_pcm_model.sv
// pcgf_pcm_model: pcm bus master and gci slave facing the codec strobe and gci block
// assumes: tb resolves the data pins; half-bit steps on falling edges of the link clock
`timescale 1ns/1ps
`default_nettype none
module pcgf_pcm_model #(
  parameter logic [10:0] HB_LAST = 11'h1ff
) (
  output logic lclk,
  output logic fpulse,
  output logic [10:0] hb,
  input wire logic out_pin,
  output logic slave_drv,
  input wire logic slave_on,
  input wire logic [4:0] grp,
  input wire logic [7:0] slave_mon,
  input wire logic [7:0] slave_ci
);
  logic [7:0] cap [0:127];
  logic [10:0] nh;
  // ----------------------------------------------------------------
  // link clock, free running at an odd phase to the core clock
  // ----------------------------------------------------------------
  // double rate clock and frame pulse
  initial begin
    lclk = 1'b1;
    fpulse = 1'b0;
    hb = HB_LAST;
    slave_drv = 1'b1;
    #37;
    forever #400 lclk = ~lclk;
  end
  // pulse spans the falling edge that restarts slot zero
  always @(posedge lclk) begin
    fpulse <= (hb == HB_LAST);
  end
  // capture at the end of each bit, drive at each bit start
  // slave side of frame
  always @(negedge lclk) begin
    nh = (hb == HB_LAST) ? 11'h000 : hb + 11'h001;
    if (hb[0]) begin
      cap[hb[10:4]][~hb[3:1]] <= out_pin;
    end
    hb <= nh;
    if (!nh[0]) begin
      if (slave_on && nh[10:4] == {grp, 2'b11}) begin
        slave_drv <= slave_ci[~nh[3:1]];
      end else if (slave_on && nh[10:4] == {grp, 2'b10}) begin
        slave_drv <= slave_mon[~nh[3:1]];
      end else begin
        slave_drv <= ~slave_drv; // released line never holds a stale level
      end
    end
  end
endmodule : pcgf_pcm_model
`default_nettype wire

// >>> verif/pcgf_top_tb.sv
// pcgf_top_tb: register, strobe and gci frame tests for pcgf_top
// assumes: pcgf_pcm_model plays pcm master and gci slave on the pins
`timescale 1ns/1ps
`default_nettype none
module pcgf_top_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, lclk, fpulse, slave_drv, out_do, out_oe, in_do, in_oe;
  logic strobe_a, strobe_b, out_pin, in_pin;
  logic [10:0] hb;
  logic slave_on = 1'b0;
  logic [7:0] slave_mon = 8'hff;
  logic [7:0] slave_ci = 8'hff;
  int n_errors = 0;
  int tests_run = 0;
  localparam logic [15:0] P0 = 16'h03f8;
  localparam logic [15:0] P1 = 16'hf01f;
  logic [3:0] idx_tab [6] = '{4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf};
  logic [7:0] val_tab [6] = '{8'h1f, 8'h80, 8'hf8, 8'h03, 8'h1f, 8'hf0};
  // undriven pins show a changing level, never a stale one
  assign out_pin = out_oe ? out_do : hb[0];
  assign in_pin = in_oe ? in_do : slave_drv;
  always #50 core_clk = ~core_clk;
  pcgf_top pcgf_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .double_rate_bit_clock(lclk), .frame_pulse(fpulse), .serial_line_out_di(out_pin),
    .serial_line_out_do(out_do), .serial_line_out_oe(out_oe), .serial_line_in_di(in_pin),
    .serial_line_in_do(in_do), .serial_line_in_oe(in_oe), .codec_strobe_a(strobe_a),
    .codec_strobe_b(strobe_b));
  pcgf_pcm_model pcgf_pcm_model_i (.lclk(lclk), .fpulse(fpulse), .hb(hb), .out_pin(out_pin),
    .slave_drv(slave_drv), .slave_on(slave_on), .grp(5'h01), .slave_mon(slave_mon),
    .slave_ci(slave_ci));
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // request held until waitrequest is sampled low; bounded wait
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) n_errors++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd_chk
  // returns at the falling edge that starts slot zero
  task automatic wait_frame(input int frames);
    int n;
    repeat (frames) begin
      n = 0;
      do begin
        @(negedge lclk);
        n++;
      end while (hb !== pcgf_pkg::HB_LAST_32 && n < 600);
      if (n >= 600) n_errors++;
    end
  endtask : wait_frame
  function automatic logic pat_bit(input logic [15:0] p, input int k);
    return (k < 16) ? p[k] : p[15];
  endfunction : pat_bit
  task automatic end_sim;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    check({27'h0, avs_readdata[0], strobe_a, strobe_b, out_oe, in_oe}, 32'h0);
    rd_chk(pcgf_pkg::ADR_GCI_CFG, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, pcgf_pkg::ADR_PCM_MODE, {28'h0, idx_tab[i]});
      xfer(1'b1, pcgf_pkg::ADR_MUX_DATA, {24'h0, val_tab[i]});
    end
    // unused index with the 128-slot frame code, restored by the next loop
    xfer(1'b1, pcgf_pkg::ADR_PCM_MODE, 32'h25);
    rd_chk(pcgf_pkg::ADR_PCM_MODE, 32'h25);
    xfer(1'b1, pcgf_pkg::ADR_MUX_DATA, 32'h55);
    rd_chk(pcgf_pkg::ADR_MUX_DATA, 32'h0);
    rd_chk(5'h18, 32'h0);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, pcgf_pkg::ADR_PCM_MODE, {28'h0, idx_tab[i]});
      rd_chk(pcgf_pkg::ADR_MUX_DATA, {24'h0, val_tab[i]});
    end
    $display("test registers done");
    wait_frame(2);
    for (int k = 0; k < 40; k++) begin
      @(negedge lclk);
      check({21'h0, hb}, k);
      check({31'h0, strobe_a}, {31'h0, pat_bit(P0, k)});
      check({31'h0, strobe_b}, {31'h0, (k < 16) ? P1[15] : pat_bit(P1, k - 16)});
      check({31'h0, out_oe}, 32'h0);
    end
    $display("test strobes done");
    xfer(1'b1, pcgf_pkg::ADR_GCI_CMD, 32'h5);
    // group one stays inside a 32-slot frame
    xfer(1'b1, pcgf_pkg::ADR_GCI_CFG, 32'h101);
    wait_frame(2);
    check({24'h0, pcgf_pcm_model_i.cap[7]}, 32'hd7);
    check({24'h0, pcgf_pcm_model_i.cap[6]}, 32'hff);
    xfer(1'b1, pcgf_pkg::ADR_MON_TX, 32'ha5);
    wait_frame(1);
    check({23'h0, pcgf_pcm_model_i.cap[6], pcgf_pcm_model_i.cap[7][0]}, 32'h14a);
    wait_frame(1);
    check({23'h0, pcgf_pcm_model_i.cap[6], pcgf_pcm_model_i.cap[7][0]}, 32'h1ff);
    xfer(1'b1, pcgf_pkg::ADR_GCI_CFG, 32'h103);
    xfer(1'b1, pcgf_pkg::ADR_GCI_CMD, 32'h2a);
    wait_frame(2);
    check({24'h0, pcgf_pcm_model_i.cap[7]}, 32'hab);
    $display("test gci transmit done");
    slave_mon <= 8'h3c;
    slave_ci <= 8'hea;
    slave_on <= 1'b1;
    wait_frame(2);
    rd_chk(pcgf_pkg::ADR_GCI_STAT, 32'h2ba3c);
    wait_frame(1);
    check({31'h0, pcgf_pcm_model_i.cap[7][1]}, 32'h0);
    $display("test gci receive done");
    // swapped lines: the idle monitor byte goes out on the incoming pin
    xfer(1'b1, pcgf_pkg::ADR_GCI_CFG, 32'h107);
    rd_chk(pcgf_pkg::ADR_GCI_CFG, 32'h107);
    wait_frame(1);
    repeat (98) @(negedge lclk);
    check({30'h0, out_oe, in_oe}, 32'h1);
    check({31'h0, in_do}, 32'h1);
    $display("test gci swap done");
    end_sim;
  end
  // watchdog: the tests need about twelve frames
  initial begin
    #9_000_000;
    n_errors++;
    end_sim;
  end
endmodule : pcgf_top_tb
`default_nettype wire
